/* design/stream_read_pkg.sv */
// Shared constants, field layouts and carrier types of the stream read block
package stream_read_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned TICK_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W = 8;
  localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [39:0] MIN_LIMIT_US = 40'h0000000064;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] OFF_FLAGS = 7'h00;
  localparam logic [6:0] OFF_TLIM = 7'h04;
  localparam logic [6:0] OFF_CNT_LO = 7'h08;
  localparam logic [6:0] OFF_CNT_HI = 7'h0c;
  localparam logic [6:0] OFF_LBA0 = 7'h10;
  localparam logic [6:0] OFF_LBA_MID = 7'h14;
  localparam logic [6:0] OFF_LBA_HI = 7'h18;
  localparam logic [6:0] OFF_COMMAND = 7'h1c;
  localparam logic [6:0] OFF_TIME_UNIT = 7'h20;
  localparam logic [6:0] OFF_STREAM_CFG = 7'h24;
  localparam logic [6:0] OFF_STATUS = 7'h28;
  localparam logic [6:0] OFF_ERR_LOG = 7'h2c;
  localparam logic [6:0] OFF_RES_LBA_LO = 7'h30;
  localparam logic [6:0] OFF_RES_LBA_HI = 7'h34;
  localparam logic [6:0] OFF_RES_COUNT = 7'h38;
  localparam logic [6:0] OFF_IRQ_STAT = 7'h3c;
  localparam logic [6:0] OFF_IRQ_MASK = 7'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, codes and reset values
  localparam logic [7:0] CMD_READ_STREAM = 8'h2a;
  localparam int unsigned URG_BIT = 7;
  localparam int unsigned CONT_BIT = 6;
  localparam int unsigned NSEQ_BIT = 5;
  localparam int unsigned HSE_BIT = 4;
  localparam int unsigned CFG_VALID_BIT = 16;
  localparam int unsigned LOG_CRC = 7;
  localparam int unsigned LOG_UNC = 6;
  localparam int unsigned LOG_ID_NOT_FOUND_ERROR = 4;
  localparam int unsigned LOG_ABORTED_COMMAND_ERROR = 2;
  localparam int unsigned LOG_COMPLETION_TIMEOUT_FLAG = 0;
  localparam int unsigned ST_BSY = 7;
  localparam int unsigned ST_SE = 5;
  localparam int unsigned ST_ERR = 0;
  localparam int unsigned IRQ_W = 4;
  localparam logic [16:0] FULL_COUNT = 17'h10000;
  localparam logic [31:0] TIME_UNIT_RST = 32'h00000001;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [1:0] {PH_IDLE, PH_LOOKUP, PH_RUN} phase_type;

  typedef struct packed {
    logic crc;
    logic uncorrectable_error;
    logic id_not_found_error;
    logic aborted_command_error;
  } media_err_type;

  typedef struct packed {
    logic valid;
    logic [7:0] limit;
  } cfg_type;

  typedef struct packed {
    logic urgent;
    logic cont;
    logic nseq;
    logic handle_stream_error_flag;
    logic [2:0] stream_sel;
    logic [7:0] mult;
    logic [16:0] count;
    logic [47:0] lba;
  } cmd_type;

  typedef struct packed {
    logic start;
    logic halt;
    logic urgent;
    logic nseq;
    logic resume;
    logic [2:0] stream_sel;
    logic [16:0] count;
    logic [47:0] lba;
  } xfer_type;

endpackage

/* design/stream_cfg_mem.sv */
// Per-stream default time limit store with registered read
`timescale 1ns/10ps
`default_nettype none
module stream_cfg_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire stream_read_pkg::cfg_type wr_cfg,
  input wire logic [AW-1:0] rd_addr,
  output stream_read_pkg::cfg_type rd_cfg
);

  typedef struct packed {
    stream_read_pkg::cfg_type [DEPTH-1:0] mem;
    stream_read_pkg::cfg_type rd;
  } mem_state_type;

  mem_state_type q;
  mem_state_type d;

  ////////////////////////////////////////////////////////////////////////////
  // Entry update and read register
  always_comb begin
    d = q;
    for (int i = 0; i < DEPTH; i++) begin
      if (wr_en && wr_addr == AW'(i)) begin
        d.mem[i] = wr_cfg;
      end
    end
    d.rd = q.mem[rd_addr];
  end

  // Empty entries read as never configured
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_cfg = q.rd;

endmodule
`default_nettype wire

/* design/completion_timer.sv */
// Microsecond down-counter for the command completion limit
`timescale 1ns/10ps
`default_nettype none
module completion_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load,
  input wire logic limited,
  input wire logic [39:0] value,
  input wire logic stop,
  output logic expired
);

  typedef struct packed {
    logic [stream_read_pkg::DIV_W-1:0] div;
    logic [39:0] cnt;
    logic armed;
    logic expired;
  } tmr_state_type;

  tmr_state_type q;
  tmr_state_type d;
  logic tick;

  assign tick = (q.div == stream_read_pkg::TICK_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Divider and down-counter
  always_comb begin
    d = q;
    d.div = tick ? '0 : q.div + 1'b1;
    if (load) begin
      d.cnt = value;
      d.armed = limited;
      d.expired = 1'b0;
      d.div = '0;
    end else if (stop) begin
      d.armed = 1'b0;
      d.expired = 1'b0;
    end else if (q.armed && tick) begin
      if (q.cnt <= 40'h0000000001) begin
        d.expired = 1'b1;
        d.armed = 1'b0;
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt - 40'h0000000001;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.expired;

  // Expiry only from an armed count
  expire_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(q.expired) |-> $past(q.armed))
    else $error("timer expired while not armed");

endmodule
`default_nettype wire

/* design/stream_read_ctrl.sv */
// Stream read command decode, completion limit and ending status
//
// Behaviour
// - urgent: finish fast, within time limit
// - continuous read never aborts on errors
// - continuous errors: full transfer, stream error
// - continuous timeout: halt, stream error, timeout
// - always try whole amount within limit (a plain read here halts at its first bad sector)
// - error-resume start at last error address (here only passed on as xfer.resume; start stays the command LBA)
// - stream selector picks stream settings
// - limit = multiplier times identify time unit
// - zero multiplier uses stream default
// - no default means no limit
// - time from command write to completion
// - limit below minimum raised to minimum
// - count from two bytes, zero means 65536
// - report first bad address and run
// - timeout flag on limit overrun
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module stream_read_ctrl #(
  parameter logic [39:0] MIN_LIMIT_US = stream_read_pkg::MIN_LIMIT_US
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [6:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic sector_done,
  input wire stream_read_pkg::media_err_type sector_err,
  output stream_read_pkg::xfer_type xfer,
  output logic busy,
  output logic irq
);

  typedef struct packed {
    stream_read_pkg::phase_type phase;
    logic [7:0] flags;
    logic [7:0] mult;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [47:0] lba_in;
    logic [31:0] unit;
    stream_read_pkg::cmd_type cmd;
    logic [16:0] done_cnt;
    logic [47:0] bad_lba;
    logic [16:0] bad_run;
    logic bad_open;
    logic seen_err;
    logic [7:0] err_log;
    logic se;
    logic err;
    logic busy;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic irq;
    logic [31:0] rd_data;
    stream_read_pkg::xfer_type xfer;
    logic tmr_load;
    logic tmr_stop;
    logic tmr_limited;
    logic [39:0] tmr_value;
  } ctl_state_type;

  ctl_state_type q;
  ctl_state_type d;

  logic cmd_ok;
  logic any_err;
  logic limited;
  logic cfg_we;
  logic fin;
  logic tmr_expired;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [7:0] sel_lim;
  logic [39:0] prod;
  logic [47:0] cur_lba;
  logic [16:0] done_nx;
  logic [16:0] req_cnt;
  logic [2:0] rd_sel;
  stream_read_pkg::cfg_type cfg_rd;
  stream_read_pkg::cfg_type cfg_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Stream defaults and completion timer

  assign rd_sel = (q.phase == stream_read_pkg::PH_IDLE) ?
                  q.flags[2:0] : q.cmd.stream_sel;
  assign cfg_we = wr_en && addr == stream_read_pkg::OFF_STREAM_CFG;
  assign cfg_wr.valid = wr_data[stream_read_pkg::CFG_VALID_BIT];
  assign cfg_wr.limit = wr_data[15:8];

  stream_cfg_mem #(
    .DEPTH(8),
    .AW(3)
  ) u_cfg (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(cfg_we),
    .wr_addr(wr_data[2:0]),
    .wr_cfg(cfg_wr),
    .rd_addr(rd_sel),
    .rd_cfg(cfg_rd)
  );

  completion_timer u_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(q.tmr_load),
    .limited(q.tmr_limited),
    .value(q.tmr_value),
    .stop(q.tmr_stop),
    .expired(tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helper terms

  assign req_cnt = ({q.cnt_hi, q.cnt_lo} == 16'h0000) ?
                   stream_read_pkg::FULL_COUNT : {1'b0, q.cnt_hi, q.cnt_lo};
  assign sel_lim = (q.cmd.mult != 8'h00) ? q.cmd.mult : cfg_rd.limit;
  assign limited = (q.cmd.mult != 8'h00) ||
                   (cfg_rd.valid && cfg_rd.limit != 8'h00);
  assign prod = {32'h00000000, sel_lim} * {8'h00, q.unit};
  assign any_err = |sector_err;
  assign cur_lba = q.cmd.lba + {31'h00000000, q.done_cnt};
  assign done_nx = q.done_cnt + 17'h00001;
  assign cmd_ok = wr_en && addr == stream_read_pkg::OFF_COMMAND &&
                  wr_data[7:0] == stream_read_pkg::CMD_READ_STREAM &&
                  q.phase == stream_read_pkg::PH_IDLE;
  assign clr = (wr_en && addr == stream_read_pkg::OFF_IRQ_STAT) ?
               wr_data[3:0] : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    d = q;
    fin = 1'b0;
    d.xfer.start = 1'b0;
    d.xfer.halt = 1'b0;
    d.tmr_load = 1'b0;
    d.tmr_stop = 1'b0;
    d.rd_data = '0;
    // Parameter register writes
    if (wr_en) begin
      case (addr)
        stream_read_pkg::OFF_FLAGS: d.flags = wr_data[7:0];
        stream_read_pkg::OFF_TLIM: d.mult = wr_data[7:0];
        stream_read_pkg::OFF_CNT_LO: d.cnt_lo = wr_data[7:0];
        stream_read_pkg::OFF_CNT_HI: d.cnt_hi = wr_data[7:0];
        stream_read_pkg::OFF_LBA0: d.lba_in[7:0] = wr_data[7:0];
        stream_read_pkg::OFF_LBA_MID: d.lba_in[31:8] = wr_data[23:0];
        stream_read_pkg::OFF_LBA_HI: d.lba_in[47:32] = wr_data[15:0];
        stream_read_pkg::OFF_TIME_UNIT: d.unit = wr_data;
        stream_read_pkg::OFF_IRQ_MASK: d.irq_mask = wr_data[3:0];
        default: ;
      endcase
    end
    // Register reads, unmapped read zero
    if (rd_en) begin
      case (addr)
        stream_read_pkg::OFF_TIME_UNIT: d.rd_data = q.unit;
        stream_read_pkg::OFF_STATUS: begin
          d.rd_data[stream_read_pkg::ST_BSY] = q.busy;
          d.rd_data[stream_read_pkg::ST_SE] = q.se;
          d.rd_data[stream_read_pkg::ST_ERR] = q.err;
        end
        stream_read_pkg::OFF_ERR_LOG: d.rd_data = {24'h000000, q.err_log};
        stream_read_pkg::OFF_RES_LBA_LO: d.rd_data = q.bad_lba[31:0];
        stream_read_pkg::OFF_RES_LBA_HI: d.rd_data = {16'h0000, q.bad_lba[47:32]};
        stream_read_pkg::OFF_RES_COUNT: d.rd_data = {15'h0000, q.bad_run};
        stream_read_pkg::OFF_IRQ_STAT: d.rd_data = {28'h0000000, q.irq_stat};
        stream_read_pkg::OFF_IRQ_MASK: d.rd_data = {28'h0000000, q.irq_mask};
        default: d.rd_data = '0;
      endcase
    end
    // Command sequencing
    case (q.phase)
      stream_read_pkg::PH_IDLE: begin
        if (cmd_ok) begin
          d.cmd.urgent = q.flags[stream_read_pkg::URG_BIT];
          d.cmd.cont = q.flags[stream_read_pkg::CONT_BIT];
          d.cmd.nseq = q.flags[stream_read_pkg::NSEQ_BIT];
          d.cmd.handle_stream_error_flag = q.flags[stream_read_pkg::HSE_BIT];
          d.cmd.stream_sel = q.flags[2:0];
          d.cmd.mult = q.mult;
          d.cmd.count = req_cnt;
          d.cmd.lba = q.lba_in;
          d.done_cnt = '0;
          d.bad_lba = '0;
          d.bad_run = '0;
          d.bad_open = 1'b0;
          d.seen_err = 1'b0;
          d.err_log = '0;
          d.se = 1'b0;
          d.err = 1'b0;
          d.phase = stream_read_pkg::PH_LOOKUP;
        end
      end
      stream_read_pkg::PH_LOOKUP: begin
        d.tmr_load = 1'b1;
        d.tmr_limited = limited;
        d.tmr_value = (prod < MIN_LIMIT_US) ? MIN_LIMIT_US : prod;
        d.xfer.urgent = q.cmd.urgent;
        d.xfer.nseq = q.cmd.nseq;
        d.xfer.resume = q.cmd.handle_stream_error_flag;
        d.xfer.stream_sel = q.cmd.stream_sel;
        d.xfer.count = q.cmd.count;
        d.xfer.lba = q.cmd.lba;
        d.xfer.start = 1'b1;
        d.phase = stream_read_pkg::PH_RUN;
      end
      stream_read_pkg::PH_RUN: begin
        if (tmr_expired) begin
          d.err_log[stream_read_pkg::LOG_COMPLETION_TIMEOUT_FLAG] = 1'b1;
          d.xfer.halt = 1'b1;
          d.se = q.cmd.cont;
          d.err = !q.cmd.cont;
          fin = 1'b1;
        end else if (sector_done) begin
          d.done_cnt = done_nx;
          if (any_err) begin
            d.err_log[stream_read_pkg::LOG_CRC] = q.err_log[7] | sector_err.crc;
            d.err_log[stream_read_pkg::LOG_UNC] = q.err_log[6] | sector_err.uncorrectable_error;
            d.err_log[stream_read_pkg::LOG_ID_NOT_FOUND_ERROR] =
              q.err_log[4] | sector_err.id_not_found_error;
            d.err_log[stream_read_pkg::LOG_ABORTED_COMMAND_ERROR] =
              q.err_log[2] | sector_err.aborted_command_error;
            d.seen_err = 1'b1;
            if (!q.seen_err) begin
              d.bad_lba = cur_lba;
              d.bad_run = 17'h00001;
              d.bad_open = 1'b1;
            end else if (q.bad_open) begin
              d.bad_run = q.bad_run + 17'h00001;
            end
          end else begin
            d.bad_open = 1'b0;
          end
          if (any_err && !q.cmd.cont) begin
            d.err = 1'b1;
            d.xfer.halt = 1'b1;
            fin = 1'b1;
          end else if (done_nx == q.cmd.count) begin
            d.se = q.cmd.cont && (q.seen_err || any_err);
            fin = 1'b1;
          end
        end
        if (fin) begin
          d.tmr_stop = 1'b1;
          d.phase = stream_read_pkg::PH_IDLE;
        end
      end
      default: d.phase = stream_read_pkg::PH_IDLE;
    endcase
    // Completion events, set beats clear
    ev = fin ? {d.err, d.err_log[stream_read_pkg::LOG_COMPLETION_TIMEOUT_FLAG], d.se, 1'b1} :
               4'h0;
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq = |(d.irq_stat & d.irq_mask);
    d.busy = (d.phase != stream_read_pkg::PH_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.phase <= stream_read_pkg::PH_IDLE;
      q.unit <= stream_read_pkg::TIME_UNIT_RST;
      q.irq_mask <= stream_read_pkg::IRQ_MASK_RST;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;
  assign xfer = q.xfer;
  assign busy = q.busy;
  assign irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  cmd_busy_a: assert property (cmd_ok |=> busy ##1 xfer.start)
    else $error("command not taken");

  count_full_a: assert property (
    cmd_ok && q.cnt_lo == 8'h00 && q.cnt_hi == 8'h00 |->
      ##2 xfer.count == stream_read_pkg::FULL_COUNT)
    else $error("zero count not full");

  cont_keep_a: assert property (
    q.phase == stream_read_pkg::PH_RUN && q.cmd.cont && sector_done &&
    any_err && !tmr_expired && done_nx != q.cmd.count |=> busy)
    else $error("continuous read stopped on error");

  plain_abort_a: assert property (
    q.phase == stream_read_pkg::PH_RUN && !q.cmd.cont && sector_done &&
    any_err && !tmr_expired |=> !busy && q.err && xfer.halt)
    else $error("plain read did not abort");

  cont_status_a: assert property (
    $fell(busy) && q.cmd.cont && (|q.err_log[7:1]) |-> q.se && !q.err)
    else $error("continuous error status wrong");

  timeout_end_a: assert property (
    q.phase == stream_read_pkg::PH_RUN && tmr_expired |=>
      !busy && q.err_log[0] && q.se == q.cmd.cont && xfer.halt)
    else $error("timeout ending wrong");

  limit_min_a: assert property (
    q.tmr_load && q.tmr_limited |-> q.tmr_value >= MIN_LIMIT_US)
    else $error("limit below minimum");

  no_limit_a: assert property (
    q.phase == stream_read_pkg::PH_LOOKUP && q.cmd.mult == 8'h00 &&
    !cfg_rd.valid |=> q.tmr_load && !q.tmr_limited)
    else $error("limit applied without configuration");

  done_irq_a: assert property (
    $fell(busy) && q.irq_mask[0] |-> irq && q.irq_stat[0])
    else $error("completion interrupt missing");

  first_bad_a: assert property (
    q.phase == stream_read_pkg::PH_RUN && sector_done && any_err &&
    !q.seen_err && !tmr_expired |=> q.bad_lba == $past(cur_lba) &&
      q.bad_run == 17'h00001)
    else $error("first bad sector not recorded");

  plain_done_c: cover property ($fell(busy) && !q.err && !q.se);
  cont_err_c: cover property ($fell(busy) && q.se && !q.err_log[0]);
  timeout_c: cover property ($fell(busy) && q.err_log[0]);

endmodule
`default_nettype wire

/* tb/media_model.sv */
// Media engine model answering transfer starts with sector pulses
`timescale 1ns/10ps
`default_nettype none
module media_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire stream_read_pkg::xfer_type xfer,
  input wire logic [7:0] gap,
  input wire logic [3:0] bad_mask,
  input wire logic [16:0] bad_first,
  input wire logic [16:0] bad_last,
  output logic sector_done,
  output stream_read_pkg::media_err_type sector_err
);
  logic [16:0] left_q;
  logic [16:0] idx_q;
  logic [7:0] wait_q;

  // One sector every gap+1 cycles until count is met or halt arrives
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 17'h00000;
      idx_q <= 17'h00000;
      wait_q <= 8'h00;
      sector_done <= 1'b0;
      sector_err <= 4'ha;
    end else if (xfer.start) begin
      left_q <= xfer.count;
      idx_q <= 17'h00000;
      wait_q <= gap;
      sector_done <= 1'b0;
    end else if (xfer.halt) begin
      left_q <= 17'h00000;
      sector_done <= 1'b0;
    end else if (left_q != 17'h00000 && wait_q == 8'h00) begin
      sector_done <= 1'b1;
      sector_err <= (idx_q >= bad_first && idx_q <= bad_last) ? bad_mask : 4'h0;
      idx_q <= idx_q + 17'h00001;
      left_q <= left_q - 17'h00001;
      wait_q <= gap;
    end else begin
      // Error lines toggle while no sector is flagged
      sector_done <= 1'b0;
      sector_err <= ~sector_err;
      wait_q <= (wait_q != 8'h00) ? wait_q - 8'h01 : 8'h00;
    end
  end
endmodule
`default_nettype wire

/* tb/stream_read_ctrl_tb.sv */
// Self-checking bench for the stream read command controller
`timescale 1ns/10ps
`default_nettype none
module stream_read_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [31:0] wr_data = 32'h00000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic sector_done;
  stream_read_pkg::media_err_type sector_err;
  stream_read_pkg::xfer_type xfer;
  stream_read_pkg::xfer_type x_cap;
  logic busy;
  logic irq;
  logic [7:0] gap = 8'h00;
  logic [3:0] bad_mask = 4'h0;
  logic [16:0] bad_first = 17'h1ffff;
  logic [16:0] bad_last = 17'h00000;
  int n_fail = 0;
  int num_checks = 0;
  int n_cyc;
  logic saw_halt;
  logic [31:0] v;

  // Clock at 100 ns period
  always #50 clk_sys = ~clk_sys;

  stream_read_ctrl #(.MIN_LIMIT_US(40'h0000000002)) dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .sector_done(sector_done),
    .sector_err(sector_err),
    .xfer(xfer),
    .busy(busy),
    .irq(irq)
  );

  media_model media_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .xfer(xfer),
    .gap(gap),
    .bad_mask(bad_mask),
    .bad_first(bad_first),
    .bad_last(bad_last),
    .sector_done(sector_done),
    .sector_err(sector_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    chk(32'h0, 32'h1);
    tally_and_finish();
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys); // Gap edge, strobe never retoggled in one step
  endtask

  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
    @(posedge clk_sys);
  endtask

  // Load parameters, issue the command, capture the launched transfer
  task automatic cmd(input logic [7:0] fl, input logic [7:0] ml,
                     input logic [15:0] cnt, input logic [47:0] lba);
    int i;
    wr(stream_read_pkg::OFF_FLAGS, {24'h0, fl});
    wr(stream_read_pkg::OFF_TLIM, {24'h0, ml});
    wr(stream_read_pkg::OFF_CNT_LO, {24'h0, cnt[7:0]});
    wr(stream_read_pkg::OFF_CNT_HI, {24'h0, cnt[15:8]});
    wr(stream_read_pkg::OFF_LBA0, {24'h0, lba[7:0]});
    wr(stream_read_pkg::OFF_LBA_MID, {8'h0, lba[31:8]});
    wr(stream_read_pkg::OFF_LBA_HI, {16'h0, lba[47:32]});
    wr(stream_read_pkg::OFF_COMMAND, 32'h0000002a);
    @(negedge clk_sys);
    chk(busy, 1'b1);
    i = 0;
    while (xfer.start !== 1'b1) begin
      i++;
      if (i > 4) hang();
      @(negedge clk_sys);
    end
    x_cap = xfer;
    @(posedge clk_sys);
  endtask

  // Wait for busy to fall, noting any halt pulse
  task automatic wait_idle(input int lim);
    n_cyc = 0;
    saw_halt = 1'b0;
    @(negedge clk_sys);
    while (busy !== 1'b0) begin
      n_cyc++;
      if (n_cyc > lim) hang();
      @(negedge clk_sys);
      if (xfer.halt === 1'b1) saw_halt = 1'b1;
    end
    @(posedge clk_sys);
  endtask

  // Ending status, log, interrupt raise and clear
  task automatic ending(input logic [7:0] st, input logic [7:0] lg,
                        input logic [3:0] im);
    rd(stream_read_pkg::OFF_STATUS, v);
    chk(v & 32'ha1, {24'h0, st});
    rd(stream_read_pkg::OFF_ERR_LOG, v);
    chk(v & 32'hd5, {24'h0, lg});
    rd(stream_read_pkg::OFF_IRQ_STAT, v);
    chk(v & {28'h0, im}, {28'h0, im});
    @(negedge clk_sys);
    chk(irq, 1'b1);
    @(posedge clk_sys);
    wr(stream_read_pkg::OFF_IRQ_STAT, 32'h0000000f);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    @(negedge clk_sys);
    chk({busy, irq}, 2'b00);
    chk({31'h00000000, |xfer}, 32'h00000000);
    @(posedge clk_sys);
    rd(stream_read_pkg::OFF_TIME_UNIT, v);
    chk(v, 32'h00000001);
    rd(stream_read_pkg::OFF_IRQ_MASK, v);
    chk(v, 32'h00000000);
    rd(7'h7c, v);
    chk(v, 32'h00000000);
    wr(stream_read_pkg::OFF_FLAGS, 32'h000000ff);
    rd(stream_read_pkg::OFF_FLAGS, v);
    chk(v, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic t_basic();
    gap <= 8'h02;
    cmd(8'ha5, 8'h00, 16'h0003, 48'h123456789abc);
    chk({x_cap.urgent, x_cap.nseq}, 2'b11);
    chk(x_cap.stream_sel, 3'h5);
    chk(x_cap.count, 17'h00003);
    chk(x_cap.lba[31:0], 32'h56789abc);
    chk({16'h0000, x_cap.lba[47:32]}, 32'h00001234);
    wr(stream_read_pkg::OFF_FLAGS, 32'h00000002);
    @(negedge clk_sys);
    chk({xfer.urgent, xfer.stream_sel, xfer.lba[27:0]}, 32'hd6789abc);
    wait_idle(100);
    chk(saw_halt, 1'b0);
    chk(irq, 1'b0);
    wr(stream_read_pkg::OFF_IRQ_MASK, 32'h0000000f);
    ending(8'h00, 8'h00, 4'h1);
    $display("test basic done");
  endtask

  task automatic t_cont_err();
    gap <= 8'h01;
    bad_first <= 17'h00001;
    bad_last <= 17'h00002;
    bad_mask <= 4'hc;
    cmd(8'h41, 8'h00, 16'h0004, 48'h000000001000);
    wait_idle(200);
    chk(saw_halt, 1'b0);
    ending(8'h20, 8'hc0, 4'h3);
    rd(stream_read_pkg::OFF_RES_LBA_LO, v);
    chk(v, 32'h00001001);
    rd(stream_read_pkg::OFF_RES_COUNT, v);
    chk(v, 32'h00000002);
    bad_first <= 17'h1ffff;
    $display("test continuous errors done");
  endtask

  // Continuous read cut short by the completion limit
  task automatic t_limit(input logic [7:0] fl, input logic [7:0] ml,
                         input int lo, input int hi);
    gap <= 8'hff;
    cmd(fl, ml, 16'h0001, 48'h0);
    wait_idle(300);
    chk(32'(n_cyc >= lo && n_cyc <= hi), 32'h1);
    chk(saw_halt, 1'b1);
    ending(8'h20, 8'h01, 4'h6);
    $display("test limit done");
  endtask

  task automatic t_nolimit();
    gap <= 8'h96;
    wr(stream_read_pkg::OFF_STREAM_CFG, 32'h00010002);
    for (int k = 0; k < 2; k++) begin
      cmd(k == 0 ? 8'h42 : 8'h46, 8'h00, 16'h0002, 48'h0);
      wait_idle(400);
      chk(32'(n_cyc >= 290), 32'h1);
      ending(8'h00, 8'h00, 4'h1);
    end
    $display("test no limit done");
  endtask

  task automatic t_abort();
    gap <= 8'h00;
    bad_first <= 17'h00000;
    bad_last <= 17'h00000;
    bad_mask <= 4'h7;
    cmd(8'h10, 8'h00, 16'h0000, 48'h0000000000ff);
    chk(x_cap.count, 17'h10000);
    chk(x_cap.resume, 1'b1);
    wait_idle(50);
    chk(saw_halt, 1'b1);
    ending(8'h01, 8'h54, 4'h8);
    $display("test abort done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_basic();
    t_cont_err();
    t_limit(8'h40, 8'h01, 17, 25);
    wr(stream_read_pkg::OFF_TIME_UNIT, 32'h00000002);
    rd(stream_read_pkg::OFF_TIME_UNIT, v);
    chk(v, 32'h00000002);
    t_limit(8'h42, 8'h03, 57, 65);
    wr(stream_read_pkg::OFF_STREAM_CFG, 32'h00010403);
    t_limit(8'h43, 8'h00, 77, 85);
    t_nolimit();
    t_abort();
    tally_and_finish();
  end
endmodule
`default_nettype wire
